// ---- fifo_core_consts.vh ----
// Constants for the strap-configured 18-bit FIFO core: APB register map,
// status field positions, reset values and default flag offsets.
// Included by bare name; holds definitions only.
`ifndef FIFO_CORE_CONSTS_VH
`define FIFO_CORE_CONSTS_VH

// ----------------------------------------------------------------------
// APB register byte addresses
// ----------------------------------------------------------------------
`define REG_EMPTY_OFS 12'h000
`define REG_FULL_OFS 12'h004
`define REG_STATUS 12'h008

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define ST_COUNT_LSB 0
`define ST_OUT_VALID 16
`define ST_FALL_THROUGH 17
`define ST_DOUBLE_FLAGS 18
`define ST_SYNC_ALMOST 19
`define ST_EMPTY_N 20
`define ST_FULL_N 21
`define ST_ALMOST_EMPTY_N 22
`define ST_ALMOST_FULL_N 23
`define ST_HALF_FULL_N 24

// ----------------------------------------------------------------------
// Widths, reset and default values
// ----------------------------------------------------------------------
`define DATA_W 18
`define OFS_W 12
`define DEF_EMPTY_OFS 12'h01F
`define DEF_FULL_OFS 12'h01F
`define OUT_RESET 18'h00000
`define MODE_FALL_THROUGH 2'h1
`define MODE_DOUBLE 2'h2

`endif

// ---- fifo_core.v ----
// Strap-configured 18-bit FIFO core with standard and fall-through modes.
// Assumes write_clk and read_clk are slow strobes synchronous to pclk (at
// most pclk/2); their rising edges are detected in the pclk domain.
//
// Functional notes
// RL1: Latch flag timing and mode straps during reset.
// RL2: Chain wiring of straps is the system's job.
// RL3: Reset returns both pointers to first location.
// RL4: Outside logic resets before its first write.
// RL5: Reset: half, almost-full, full high; almost-empty low.
// RL6: Reset: empty low standard, output-ready high fall-through.
// RL7: Reset clears output register, reloads offset defaults.
// RL8: Write and read data paths are 18 bits.
// RL9: Write edge with enable low stores sequentially.
// RL10: Write enable high stores nothing.
// RL11: Standard full flag low when full, write-edge updated.
// RL12: Fall-through input-ready high when full, write-edge updated.
// RL13: Write enable ignored while buffer is full.
// RL14: Works with asynchronous or coincident write/read clocks.
// RL15: Read edge with enable low loads output register.
// RL16: Read enable high holds the output register.
// RL17: Standard mode reader requests every word.
// RL18: Standard empty flag, read-edge updated, reads ignored empty.
// RL19: Fall-through first word appears third read edge.
// RL20: Fall-through later reads need enable; output-ready rises empty.
// RL21: Output enable low drives data, high floats bus.
// RL22: Synchronous almost flags update on own clock only.
// RL23: Asynchronous almost flags set one clock, clear other.
// RL24: Flag buffering realised as flip-flop stages.
`include "fifo_core_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module fifo_core #(
  parameter DEPTH = 256,
  parameter ADDR_W = 8,
  parameter [11:0] DEF_EMPTY = `DEF_EMPTY_OFS,
  parameter [11:0] DEF_FULL = `DEF_FULL_OFS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reset_in_n,
  input wire first_load_strap,
  input wire read_expansion_in,
  input wire write_expansion_in,
  input wire write_clk,
  input wire write_enable_n,
  input wire [`DATA_W-1:0] write_data_in,
  input wire read_clk,
  input wire read_enable_n,
  input wire output_enable_n,
  output reg [`DATA_W-1:0] read_data_out,
  output reg read_data_oe,
  output reg empty_flag_n,
  output reg full_flag_n,
  output reg almost_empty_n,
  output reg almost_full_n,
  output reg half_full_n
);

  localparam [13:0] DEPTH14 = DEPTH[13:0];
  localparam [ADDR_W:0] DEPTH_C = DEPTH[ADDR_W:0];

  // ----------------------------------------------------------------------
  // Widening helper for fill levels
  // ----------------------------------------------------------------------
  function [13:0] widen;
    input [ADDR_W:0] v;
    begin
      widen = {{(13-ADDR_W){1'b0}}, v};
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [`DATA_W-1:0] mem [0:DEPTH-1];
  reg [ADDR_W:0] wr_ptr;
  reg [ADDR_W:0] rd_ptr;
  reg wclk_q;
  reg rclk_q;
  reg sync_almost;
  reg [1:0] mode;
  reg out_valid;
  reg [1:0] ready_pipe;
  reg empty_stage;
  reg full_stage;
  reg [`OFS_W-1:0] empty_ofs;
  reg [`OFS_W-1:0] full_ofs;

  // ----------------------------------------------------------------------
  // Clock-edge strobes and decoded mode
  // ----------------------------------------------------------------------
  // Both clocks are sampled in pclk, so tied or unrelated clocks behave alike
  wire wr_rise = write_clk & ~wclk_q; // RL14
  wire rd_rise = read_clk & ~rclk_q; // RL14
  wire fall_through_mode = (mode == `MODE_FALL_THROUGH);
  wire dbl_empty = (mode == `MODE_DOUBLE);
  wire dbl_full = (mode == `MODE_DOUBLE) | fall_through_mode;
  wire [ADDR_W:0] count = wr_ptr - rd_ptr;
  wire mem_full = (count == DEPTH_C);
  wire mem_any = (count != {(ADDR_W+1){1'b0}});

  // Write is refused while the array is full, whatever the enable says
  wire wr_do = reset_in_n & wr_rise & ~write_enable_n & ~mem_full; // RL9 RL10 RL13

  // Standard mode: every word is requested, reads ignored when empty
  wire std_load = ~fall_through_mode & rd_rise & ~read_enable_n & mem_any; // RL15 RL17 RL18
  // Fall-through: first word on third read edge, later words on request
  wire fw_first = ~out_valid & ready_pipe[1]; // RL19
  wire fw_next = out_valid & ~read_enable_n; // RL20
  wire fw_load = fall_through_mode & rd_rise & mem_any & (fw_first | fw_next);
  wire fw_drain = fall_through_mode & rd_rise & out_valid & ~read_enable_n & ~mem_any; // RL20
  wire rd_do = reset_in_n & (std_load | fw_load);

  // ----------------------------------------------------------------------
  // Next fill level, used so flags reflect the edge that just happened
  // ----------------------------------------------------------------------
  reg [ADDR_W:0] next_count;
  reg next_out_valid;
  always @* begin
    next_count = count;
    if (wr_do & ~rd_do)
      next_count = count + {{ADDR_W{1'b0}}, 1'b1};
    else if (rd_do & ~wr_do)
      next_count = count - {{ADDR_W{1'b0}}, 1'b1};
    next_out_valid = out_valid;
    if (fw_load)
      next_out_valid = 1'b1;
    else if (fw_drain)
      next_out_valid = 1'b0;
  end

  // Output register counts as one word of capacity in fall-through mode
  wire [13:0] words = widen(next_count) + {13'h0000, fall_through_mode & next_out_valid};
  wire [13:0] fw_add = {13'h0000, fall_through_mode};
  wire ae_cond = words <= ({2'b00, empty_ofs} + fw_add);
  wire af_cond = words >= (DEPTH14 + fw_add - {2'b00, full_ofs});
  wire hf_cond = words > ((DEPTH14 >> 1) + fw_add);
  wire next_full = (next_count == DEPTH_C);
  wire next_any = (next_count != {(ADDR_W+1){1'b0}});

  // ----------------------------------------------------------------------
  // Edge detectors
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      wclk_q <= write_clk;
      rclk_q <= read_clk;
    end
  end

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  // Straps are held while reset is low; the last value before release wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_almost <= 1'b0;
      mode <= 2'h0;
    end else if (!reset_in_n) begin
      sync_almost <= first_load_strap; // RL1
      mode <= {read_expansion_in, write_expansion_in}; // RL1
    end
  end

  // ----------------------------------------------------------------------
  // Array write and pointers
  // ----------------------------------------------------------------------
  always @(posedge pclk) begin
    if (wr_do)
      mem[wr_ptr[ADDR_W-1:0]] <= write_data_in; // RL8 RL9
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {(ADDR_W+1){1'b0}};
      rd_ptr <= {(ADDR_W+1){1'b0}};
    end else if (!reset_in_n) begin
      wr_ptr <= {(ADDR_W+1){1'b0}}; // RL3
      rd_ptr <= {(ADDR_W+1){1'b0}}; // RL3
    end else begin
      if (wr_do)
        wr_ptr <= wr_ptr + {{ADDR_W{1'b0}}, 1'b1};
      if (rd_do)
        rd_ptr <= rd_ptr + {{ADDR_W{1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // Output register, fall-through pipeline and output enable
  // ----------------------------------------------------------------------
  // The pipe delays the first word so it lands on the third read edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_data_out <= `OUT_RESET;
      out_valid <= 1'b0;
      ready_pipe <= 2'h0;
      read_data_oe <= 1'b0;
    end else begin
      read_data_oe <= ~output_enable_n; // RL21
      if (!reset_in_n) begin
        read_data_out <= `OUT_RESET; // RL7
        out_valid <= 1'b0;
        ready_pipe <= 2'h0;
      end else begin
        if (rd_do)
          read_data_out <= mem[rd_ptr[ADDR_W-1:0]]; // RL15 RL16
        out_valid <= next_out_valid;
        if (rd_rise)
          ready_pipe <= {ready_pipe[0] & mem_any, mem_any}; // RL19 RL24
      end
    end
  end

  // ----------------------------------------------------------------------
  // Empty / output-ready flag, read-clock domain
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_stage <= 1'b0;
      empty_flag_n <= 1'b0;
    end else if (!reset_in_n) begin
      empty_stage <= 1'b0;
      empty_flag_n <= fall_through_mode; // RL6
    end else if (rd_rise) begin
      empty_stage <= next_any; // RL24
      if (fall_through_mode)
        empty_flag_n <= ~next_out_valid; // RL20
      else
        empty_flag_n <= dbl_empty ? empty_stage : next_any; // RL18 RL24
    end
  end

  // ----------------------------------------------------------------------
  // Full / input-ready flag, write-clock domain
  // ----------------------------------------------------------------------
  // Extra stage trades a write-edge of latency for clean boundary flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_stage <= 1'b0;
      full_flag_n <= 1'b1;
    end else if (!reset_in_n) begin
      full_stage <= 1'b0;
      full_flag_n <= 1'b1; // RL5
    end else if (wr_rise) begin
      full_stage <= next_full; // RL24
      if (fall_through_mode)
        full_flag_n <= dbl_full ? full_stage : next_full; // RL12
      else
        full_flag_n <= ~(dbl_full ? full_stage : next_full); // RL11
    end
  end

  // ----------------------------------------------------------------------
  // Almost-empty, almost-full and half-full flags
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      almost_empty_n <= 1'b0;
      almost_full_n <= 1'b1;
      half_full_n <= 1'b1;
    end else if (!reset_in_n) begin
      almost_empty_n <= 1'b0; // RL5
      almost_full_n <= 1'b1; // RL5
      half_full_n <= 1'b1; // RL5
    end else begin
      if (wr_rise | rd_rise)
        half_full_n <= ~hf_cond;
      if (sync_almost) begin
        if (rd_rise)
          almost_empty_n <= ~ae_cond; // RL22
        if (wr_rise)
          almost_full_n <= ~af_cond; // RL22
      end else begin
        // Set on one side's edge, cleared by the other side's edge
        if (rd_rise & ae_cond)
          almost_empty_n <= 1'b0; // RL23
        else if (wr_rise & ~ae_cond)
          almost_empty_n <= 1'b1; // RL23
        if (wr_rise & af_cond)
          almost_full_n <= 1'b0; // RL23
        else if (rd_rise & ~af_cond)
          almost_full_n <= 1'b1; // RL23
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave: offset registers and status
  // ----------------------------------------------------------------------
  // No wait state: answer prepared in setup, pready high for the access
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite & ~pslverr;
  wire hit_e = (paddr == `REG_EMPTY_OFS);
  wire hit_f = (paddr == `REG_FULL_OFS);
  wire hit_s = (paddr == `REG_STATUS);

  reg [31:0] status_word;
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_COUNT_LSB+15:`ST_COUNT_LSB] = {{(15-ADDR_W){1'b0}}, count};
    status_word[`ST_OUT_VALID] = out_valid;
    status_word[`ST_FALL_THROUGH] = fall_through_mode;
    status_word[`ST_DOUBLE_FLAGS] = dbl_empty;
    status_word[`ST_SYNC_ALMOST] = sync_almost;
    status_word[`ST_EMPTY_N] = empty_flag_n;
    status_word[`ST_FULL_N] = full_flag_n;
    status_word[`ST_ALMOST_EMPTY_N] = almost_empty_n;
    status_word[`ST_ALMOST_FULL_N] = almost_full_n;
    status_word[`ST_HALF_FULL_N] = half_full_n;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~(hit_e | hit_f | hit_s);
      if (apb_setup & ~pwrite)
        prdata <= hit_e ? {20'h00000, empty_ofs} :
                  hit_f ? {20'h00000, full_ofs} :
                  hit_s ? status_word : 32'h00000000;
    end
  end

  // Reset pin reloads defaults and wins over a bus write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_ofs <= DEF_EMPTY;
      full_ofs <= DEF_FULL;
    end else if (!reset_in_n) begin
      empty_ofs <= DEF_EMPTY; // RL7
      full_ofs <= DEF_FULL; // RL7
    end else if (apb_wr) begin
      if (hit_e)
        empty_ofs <= pwdata[`OFS_W-1:0];
      if (hit_f)
        full_ofs <= pwdata[`OFS_W-1:0];
    end
  end

endmodule

`default_nettype wire

// ---- fifo_core_checker.sv ----
// Checker for the FIFO core: reset values, flag edges, output hold.
// Assumes strobes are sampled on pclk and straps stay still after reset.
`timescale 1ns/1ps
`default_nettype none
module fifo_core_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_in_n,
  input wire logic first_load_strap,
  input wire logic read_expansion_in,
  input wire logic write_expansion_in,
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic output_enable_n,
  input wire logic [17:0] read_data_out,
  input wire logic read_data_oe,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_n,
  input wire logic almost_full_n,
  input wire logic half_full_n
);
  // ----
  // Strobe edges as the core sees them
  // ----
  logic wclk_q;
  logic rclk_q;
  wire logic wedge = write_clk && !wclk_q;
  wire logic redge = read_clk && !rclk_q;
  // Last strobe levels; low after reset so no false edge appears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_q <= 1'h0;
      rclk_q <= 1'h0;
    end else begin
      wclk_q <= write_clk;
      rclk_q <= read_clk;
    end
  end
  logic sync_q;
  // Almost-flag timing as latched while the device reset pin is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 1'h0;
    end else if (!reset_in_n) begin
      sync_q <= first_load_strap;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // Assertions
  // ----
  oe_float_a: assert property (output_enable_n |=> !read_data_oe)
    else $error("output bus driven while disabled");
  rst_flags_a: assert property (!reset_in_n |=> full_flag_n && almost_full_n && half_full_n && !almost_empty_n)
    else $error("flag levels wrong in reset");
  rst_data_a: assert property (!reset_in_n |=> read_data_out == 18'h00000)
    else $error("output register not cleared");
  rst_ready_a: assert property (!reset_in_n && !$past(reset_in_n)
    |=> empty_flag_n == (!read_expansion_in && write_expansion_in))
    else $error("empty flag reset level wrong");
  data_hold_a: assert property (reset_in_n && !redge |=> $stable(read_data_out))
    else $error("output changed without read edge");
  full_edge_a: assert property (reset_in_n && !wedge |=> $stable(full_flag_n))
    else $error("full flag moved off write edge");
  empty_edge_a: assert property (reset_in_n && !redge |=> $stable(empty_flag_n))
    else $error("empty flag moved off read edge");
  ae_fall_a: assert property (reset_in_n && !redge |=> !$fell(almost_empty_n))
    else $error("almost empty set off read edge");
  af_fall_a: assert property (reset_in_n && !wedge |=> !$fell(almost_full_n))
    else $error("almost full set off write edge");
  ae_sync_a: assert property (reset_in_n && sync_q && !redge |=> $stable(almost_empty_n))
    else $error("almost empty moved off read edge");
  af_sync_a: assert property (reset_in_n && sync_q && !wedge |=> $stable(almost_full_n))
    else $error("almost full moved off write edge");
  ae_rise_a: assert property (reset_in_n && !sync_q && !wedge |=> !$rose(almost_empty_n))
    else $error("almost empty released off write edge");
  oe_drive_a: assert property (reset_in_n && !output_enable_n |=> read_data_oe)
    else $error("output bus not driven while enabled");
endmodule
bind fifo_core fifo_core_checker chk_u (.*);
`default_nettype wire

// ---- fifo_partner.sv ----
// Producer and consumer model for the FIFO core's data ports.
// Assumes the core sees strobe edges on pclk: one cycle low, one high.
`timescale 1ns/1ps
`default_nettype none
module fifo_partner (
  input wire logic pclk,
  output logic write_clk,
  output logic write_enable_n,
  output logic [17:0] write_data_in,
  output logic read_clk,
  output logic read_enable_n,
  output logic rd_edge
);
  // Idle levels; strobes stand still between transfers
  initial begin
    write_clk = 1'h0;
    write_enable_n = 1'h1;
    write_data_in = 18'h3FFFF;
    read_clk = 1'h0;
    read_enable_n = 1'h1;
    rd_edge = 1'h0;
  end
  // One write strobe; data is inverted once taken so a stale word cannot pass
  task automatic push(input logic [17:0] d, input logic en_n);
    @(posedge pclk);
    write_clk <= 1'h1;
    write_enable_n <= en_n;
    write_data_in <= d;
    @(posedge pclk);
    write_clk <= 1'h0;
    write_enable_n <= 1'h1;
    write_data_in <= ~d;
  endtask
  // One read strobe; rd_edge marks the cycle after the taking edge
  task automatic pull(input logic en_n);
    @(posedge pclk);
    read_clk <= 1'h1;
    read_enable_n <= en_n;
    @(posedge pclk);
    read_clk <= 1'h0;
    read_enable_n <= 1'h1;
    rd_edge <= 1'h1;
    @(posedge pclk);
    rd_edge <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- fifo_core_tb_top.sv ----
// Testbench for the FIFO core: straps, fill and drain, fall-through.
// Assumes the partner drives the data ports and APB reaches the registers.
`include "fifo_core_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module fifo_core_tb_top;
  localparam int DEPTH = 256;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic reset_in_n = 1'h0;
  logic first_load_strap = 1'h0;
  logic read_expansion_in = 1'h0;
  logic write_expansion_in = 1'h0;
  logic output_enable_n = 1'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, write_clk, write_enable_n, read_clk, read_enable_n, rd_edge;
  logic read_data_oe, empty_flag_n, full_flag_n, almost_empty_n, almost_full_n, half_full_n;
  logic [17:0] write_data_in, read_data_out;
  logic [17:0] out_m = 18'h00000;
  logic [17:0] mem[$];
  logic [17:0] exp_q[$];
  int errors = 0;
  int checked = 0;
  int seed = 32'h5204;
  fifo_core #(.DEPTH(DEPTH)) dut_u (.*);
  fifo_partner p_u (.*);
  // 10 MHz clock
  always #50 pclk = ~pclk;
  task automatic check(input string w, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", w, x, s);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // APB transfer; waits for pready as long as it takes, the watchdog bounds it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic dev_reset(input logic [2:0] s);
    @(posedge pclk);
    reset_in_n <= 1'h0;
    {first_load_strap, read_expansion_in, write_expansion_in} <= s;
    repeat (3) @(posedge pclk);
    reset_in_n <= 1'h1;
    mem.delete();
    out_m = 18'h00000;
  endtask
  task automatic wr(input logic en_n);
    logic [17:0] d;
    d = 18'($random(seed));
    if (!en_n && mem.size() < DEPTH) mem.push_back(d);
    p_u.push(d, en_n);
  endtask
  // Note the word the output register should hold after this read edge
  task automatic rd(input logic en_n);
    if (!en_n && mem.size() > 0) out_m = mem.pop_front();
    exp_q.push_back(out_m);
    p_u.pull(en_n);
  endtask
  // Scoreboard: each read edge retires the oldest noted word
  always @(posedge pclk) begin
    if (rd_edge === 1'h1) check("read data", read_data_out, exp_q.pop_front());
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    for (int s = 0; s < 8; s++) begin
      dev_reset(s[2:0]);
      @(negedge pclk);
      check("ready", empty_flag_n, s[1:0] == 2'h1);
      check("flags", {full_flag_n, almost_full_n, half_full_n, almost_empty_n}, 4'hE);
      apb(1'h0, `REG_STATUS, 32'h0);
      check("mode", q[19:17], {s[2], s[1:0] == 2'h2, s[1:0] == 2'h1});
    end
    $display("strap test done");
    dev_reset(3'h0);
    apb(1'h0, `REG_EMPTY_OFS, 32'h0);
    check("offset", q[11:0], `DEF_EMPTY_OFS);
    apb(1'h1, 12'h010, 32'h0);
    check("slverr", e, 1'h1);
    output_enable_n <= 1'h1;
    repeat (2) @(negedge pclk);
    check("drive", read_data_oe, 1'h0);
    @(posedge pclk);
    output_enable_n <= 1'h0;
    repeat (2) @(negedge pclk);
    check("drive on", read_data_oe, 1'h1);
    // Fill and drain with asynchronous, then synchronous almost flags
    for (int s = 0; s < 8; s += 4) begin
      dev_reset(s[2:0]);
      rd(1'h0);
      repeat (DEPTH) wr(1'h0);
      @(negedge pclk);
      // Synchronous almost-empty only moves on read edges, and none came during the fill
      check("full", {full_flag_n, almost_full_n, half_full_n, almost_empty_n}, {3'h0, !s[2]});
      wr(1'h0);
      rd(1'h0);
      @(negedge pclk);
      check("full kept", {full_flag_n, empty_flag_n}, 2'h1);
      wr(1'h1);
      @(negedge pclk);
      check("full gone", full_flag_n, 1'h1);
      rd(1'h1);
      fork
        wr(1'h0);
        rd(1'h0);
      join
      while (mem.size() > 0) rd(1'h0);
      rd(1'h0);
      @(negedge pclk);
      check("drained", {empty_flag_n, almost_empty_n}, 2'h0);
    end
    // Double-buffered empty flag lags one read edge behind the array
    dev_reset(3'h2);
    wr(1'h0);
    rd(1'h1);
    @(negedge pclk);
    check("double stage", empty_flag_n, 1'h0);
    rd(1'h1);
    @(negedge pclk);
    check("double flag", empty_flag_n, 1'h1);
    rd(1'h0);
    $display("fill test done");
    dev_reset(3'h1);
    wr(1'h0);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) out_m = mem.pop_front();
      exp_q.push_back(out_m);
      p_u.pull(1'h1);
    end
    @(negedge pclk);
    check("ready low", empty_flag_n, 1'h0);
    wr(1'h0);
    @(negedge pclk);
    check("input ready", full_flag_n, 1'h0);
    rd(1'h0);
    rd(1'h0);
    @(negedge pclk);
    check("ready high", empty_flag_n, 1'h1);
    rd(1'h0);
    $display("fall-through test done");
    end_of_test();
  end
  // Watchdog: the tests need about 3000 cycles
  initial begin
    repeat (8000) @(posedge pclk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
